// ==== logic/alu_core_unit.sv ====
`timescale 1ns/1ns
module alu_core_unit (
  input  wire logic [3:0]  opcode,
  input  wire logic [31:0] first,
  input  wire logic [31:0] second,
  input  wire logic        carry_in,
  output logic      [31:0] result,
  output logic             carry_out,
  output logic             overflow,
  output logic             arithmetic
);
  logic [31:0] x;
  logic [31:0] y;
  logic        ci;
  logic [32:0] sum;

  always_comb begin
    x          = first;
    y          = second;
    ci         = 1'b0;
    arithmetic = 1'b1;
    unique case (opcode)
      shift_alu_pkg::OP_SUB, shift_alu_pkg::OP_CMP: begin
        y  = ~second;
        ci = 1'b1;
      end
      shift_alu_pkg::OP_RSB: begin
        x  = second;
        y  = ~first;
        ci = 1'b1;
      end
      shift_alu_pkg::OP_ADD, shift_alu_pkg::OP_CMN: ci = 1'b0;
      shift_alu_pkg::OP_ADC: ci = carry_in;
      shift_alu_pkg::OP_SBC: begin
        y  = ~second;
        ci = carry_in;
      end
      shift_alu_pkg::OP_RSC: begin
        x  = second;
        y  = ~first;
        ci = carry_in;
      end
      default: arithmetic = 1'b0;
    endcase
  end

  assign sum = {1'b0, x} + {1'b0, y} + {32'h0000_0000, ci};

  always_comb begin
    unique case (opcode)
      shift_alu_pkg::OP_AND, shift_alu_pkg::OP_TST: result = first & second;
      shift_alu_pkg::OP_EOR, shift_alu_pkg::OP_TEQ: result = first ^ second;
      shift_alu_pkg::OP_ORR: result = first | second;
      shift_alu_pkg::OP_MOV: result = second;
      shift_alu_pkg::OP_BIC: result = first & ~second;
      shift_alu_pkg::OP_MVN: result = ~second;
      default:               result = sum[31:0];
    endcase
  end

  assign carry_out = sum[32];
  assign overflow  = (x[31] == y[31]) && (sum[31] != x[31]);
endmodule

// ==== logic/barrel_shift_unit.sv ====
`timescale 1ns/1ns
module barrel_shift_unit (
  input  wire logic [31:0] value,
  input  wire logic [7:0]  count,
  input  wire logic [1:0]  kind,
  input  wire logic        extend,
  input  wire logic        carry_in,
  output logic      [31:0] result,
  output logic             carry
);
  logic [32:0] left_wide;
  logic [32:0] right_wide;
  logic [32:0] arith_wide;
  logic [4:0]  rot;
  logic [31:0] rotated;

  assign left_wide  = {1'b0, value} << count;
  assign right_wide = {value, 1'b0} >> count;
  assign arith_wide = $signed({value, 1'b0}) >>> count;
  assign rot        = count[4:0];
  assign rotated    = (value >> rot) | (value << (6'd32 - {1'b0, rot}));

  always_comb begin
    result = value;
    carry  = carry_in;
    if (extend) begin
      result = {carry_in, value[31:1]};
      carry  = value[0];
    end else if (count == 8'h00) begin
      result = value;
      carry  = carry_in;
    end else begin
      unique case (kind)
        shift_alu_pkg::SHIFT_LSL: begin
          // Bits shifted past 33 fall off, so counts above 32 give zero and zero carry
          result = left_wide[31:0];
          carry  = left_wide[32];
        end
        shift_alu_pkg::SHIFT_LSR: begin
          result = right_wide[32:1];
          carry  = right_wide[0];
        end
        shift_alu_pkg::SHIFT_ASR: begin
          if (count >= shift_alu_pkg::COUNT_WORD) begin
            result = {32{value[31]}};
            carry  = value[31];
          end else begin
            result = arith_wide[32:1];
            carry  = arith_wide[0];
          end
        end
        shift_alu_pkg::SHIFT_ROR: begin
          if (rot == 5'h00) begin
            result = value;
            carry  = value[31];
          end else begin
            result = rotated;
            carry  = rotated[31];
          end
        end
      endcase
    end
  end
endmodule

// ==== logic/shift_alu_data_processing.sv ====
`timescale 1ns/1ns
module shift_alu_data_processing (
  input  wire logic        REF_CLK,
  input  wire logic        RSTN,
  input  wire logic        ISSUE,
  input  wire logic [31:0] INSTR,
  input  wire logic [31:0] INSTR_ADDR,
  input  wire logic [31:0] FIRST_OPERAND,
  input  wire logic [31:0] SECOND_OPERAND,
  input  wire logic [31:0] SHIFT_COUNT,
  output logic             READY,
  output logic      [31:0] RESULT,
  output logic      [3:0]  DEST_INDEX,
  output logic             RESULT_WRITE,
  output logic             PC_WRITE,
  output logic             REJECTED,
  output logic      [31:0] STATUS_WORD,
  output logic             FETCH_STROBE,
  output logic             INTERNAL_STROBE,
  output logic             DONE,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WRITE,
  input  wire logic        REG_READ,
  output logic      [31:0] REG_RDATA
);

  ////////////////////////////////////////////////////////////////////////////
  // Instruction fields

  logic        imm_form;
  logic        reg_shift;
  logic        set_flags;
  logic [3:0]  opcode;
  logic [3:0]  first_index;
  logic [3:0]  dest_index;
  logic [3:0]  second_index;
  logic [1:0]  shift_kind;
  logic [4:0]  shift_amount;
  logic        is_test;
  logic        is_data;
  logic        dest_pc;
  logic        privileged;

  assign imm_form     = INSTR[shift_alu_pkg::IMM_BIT];
  assign reg_shift    = !imm_form && INSTR[shift_alu_pkg::REGSHIFT_BIT];
  assign set_flags    = INSTR[shift_alu_pkg::S_BIT];
  assign opcode       = INSTR[shift_alu_pkg::OP_HI:shift_alu_pkg::OP_LO];
  assign first_index  = INSTR[shift_alu_pkg::RN_HI:shift_alu_pkg::RN_LO];
  assign dest_index   = INSTR[shift_alu_pkg::RD_HI:shift_alu_pkg::RD_LO];
  assign second_index = INSTR[shift_alu_pkg::RM_HI:shift_alu_pkg::RM_LO];
  assign shift_kind   = INSTR[shift_alu_pkg::STYPE_HI:shift_alu_pkg::STYPE_LO];
  assign shift_amount = INSTR[shift_alu_pkg::SHAMT_HI:shift_alu_pkg::SHAMT_LO];
  assign is_test      = (opcode[3:2] == 2'h2);
  assign dest_pc      = (dest_index == shift_alu_pkg::PC_INDEX);

  // Test opcodes without S are status transfers, handled elsewhere
  assign is_data = (INSTR[shift_alu_pkg::CLASS_HI:shift_alu_pkg::CLASS_LO] == shift_alu_pkg::CLASS_DP)
                   && !(reg_shift && INSTR[shift_alu_pkg::MUL_BIT])
                   && !(is_test && !set_flags);

  ////////////////////////////////////////////////////////////////////////////
  // Status word registers

  logic [31:0] current_status_word;
  logic [31:0] saved_status_word;

  assign privileged  = current_status_word[shift_alu_pkg::MODE_HI:shift_alu_pkg::MODE_LO]
                       != shift_alu_pkg::USER_MODE;
  assign STATUS_WORD = current_status_word;

  ////////////////////////////////////////////////////////////////////////////
  // Operand fetch

  logic [31:0] pc_read;
  logic [31:0] first_value;
  logic [31:0] second_value;

  // The prefetch pipe is one word deeper when a register supplies the shift
  assign pc_read      = INSTR_ADDR + (reg_shift ? shift_alu_pkg::PC_AHEAD_REG
                                                : shift_alu_pkg::PC_AHEAD_IMM);
  assign first_value  = (first_index == shift_alu_pkg::PC_INDEX) ? pc_read : FIRST_OPERAND;
  assign second_value = (second_index == shift_alu_pkg::PC_INDEX) ? pc_read : SECOND_OPERAND;

  ////////////////////////////////////////////////////////////////////////////
  // Second operand: barrel shifter or rotated immediate

  logic [7:0]  shift_count;
  logic        shift_extend;
  logic [31:0] shifted;
  logic        shifted_carry;
  logic [31:0] imm_value;
  logic [4:0]  imm_rot;
  logic        imm_carry;
  logic [31:0] second_op;
  logic        second_carry;
  logic        old_carry;

  assign old_carry = current_status_word[shift_alu_pkg::FLAG_C];

  always_comb begin
    shift_extend = 1'b0;
    if (reg_shift) begin
      shift_count = SHIFT_COUNT[7:0];
    end else if (shift_amount != 5'h00 || shift_kind == shift_alu_pkg::SHIFT_LSL) begin
      shift_count = {3'h0, shift_amount};
    end else if (shift_kind == shift_alu_pkg::SHIFT_ROR) begin
      shift_count  = 8'h00;
      shift_extend = 1'b1;
    end else begin
      // Encoded amount zero on a right shift stands for a full word
      shift_count = shift_alu_pkg::COUNT_WORD;
    end
  end

  barrel_shift_unit shifter (
    .value    (second_value),
    .count    (shift_count),
    .kind     (shift_kind),
    .extend   (shift_extend),
    .carry_in (old_carry),
    .result   (shifted),
    .carry    (shifted_carry)
  );

  assign imm_rot   = {INSTR[shift_alu_pkg::ROT_HI:shift_alu_pkg::ROT_LO], 1'b0};
  assign imm_value = ({24'h00_0000, INSTR[shift_alu_pkg::IMM_HI:shift_alu_pkg::IMM_LO]} >> imm_rot)
                   | ({24'h00_0000, INSTR[shift_alu_pkg::IMM_HI:shift_alu_pkg::IMM_LO]}
                      << (6'd32 - {1'b0, imm_rot}));
  // Zero rotate keeps the old carry, matching an unshifted register
  assign imm_carry = (imm_rot == 5'h00) ? old_carry : imm_value[31];

  assign second_op    = imm_form ? imm_value : shifted;
  assign second_carry = imm_form ? imm_carry : shifted_carry;

  ////////////////////////////////////////////////////////////////////////////
  // ALU and flag generation

  logic [31:0] alu_result;
  logic        alu_carry;
  logic        alu_overflow;
  logic        alu_arith;
  logic [31:0] flag_status;
  logic [31:0] next_status;

  alu_core_unit alu (
    .opcode     (opcode),
    .first      (first_value),
    .second     (second_op),
    .carry_in   (old_carry),
    .result     (alu_result),
    .carry_out  (alu_carry),
    .overflow   (alu_overflow),
    .arithmetic (alu_arith)
  );

  always_comb begin
    flag_status = current_status_word;
    flag_status[shift_alu_pkg::FLAG_N] = alu_result[31];
    flag_status[shift_alu_pkg::FLAG_Z] = (alu_result == 32'h0000_0000);
    if (alu_arith) begin
      flag_status[shift_alu_pkg::FLAG_C] = alu_carry;
      flag_status[shift_alu_pkg::FLAG_V] = alu_overflow;
    end else begin
      flag_status[shift_alu_pkg::FLAG_C] = second_carry;
    end
  end

  always_comb begin
    next_status = current_status_word;
    if (dest_pc && set_flags) begin
      if (!is_test || privileged) begin
        // Restoring both together lets a return switch modes atomically
        next_status = saved_status_word;
      end
    end else if (!dest_pc && set_flags) begin
      next_status = flag_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  shift_alu_pkg::seq_state_type state;
  shift_alu_pkg::seq_state_type next_state;
  logic [1:0] fetch_left;
  logic [1:0] cost_fetches;
  logic       cost_internal;
  logic       accept;

  assign READY  = (state == shift_alu_pkg::ST_IDLE);
  assign accept = READY && ISSUE;

  always_comb begin
    next_state = state;
    unique case (state)
      shift_alu_pkg::ST_IDLE: begin
        if (accept) begin
          if (!is_data) begin
            next_state = shift_alu_pkg::ST_IDLE;
          end else if (reg_shift) begin
            next_state = shift_alu_pkg::ST_INTERNAL;
          end else begin
            next_state = shift_alu_pkg::ST_FETCH;
          end
        end
      end
      shift_alu_pkg::ST_INTERNAL: next_state = shift_alu_pkg::ST_FETCH;
      shift_alu_pkg::ST_FETCH: begin
        if (fetch_left == 2'h1) begin
          next_state = shift_alu_pkg::ST_IDLE;
        end
      end
      default: next_state = shift_alu_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= shift_alu_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fetch_left    <= 2'h0;
      cost_fetches  <= 2'h0;
      cost_internal <= 1'b0;
    end else if (accept && is_data) begin
      // Only a real write to the program counter refills the pipe
      fetch_left    <= (dest_pc && !is_test) ? shift_alu_pkg::FETCH_PC : shift_alu_pkg::FETCH_PLAIN;
      cost_fetches  <= (dest_pc && !is_test) ? shift_alu_pkg::FETCH_PC : shift_alu_pkg::FETCH_PLAIN;
      cost_internal <= reg_shift;
    end else if (state == shift_alu_pkg::ST_FETCH) begin
      fetch_left <= fetch_left - 2'h1;
    end
  end

  assign FETCH_STROBE    = (state == shift_alu_pkg::ST_FETCH);
  assign INTERNAL_STROBE = (state == shift_alu_pkg::ST_INTERNAL);
  assign DONE            = (state == shift_alu_pkg::ST_FETCH) && (fetch_left == 2'h1);

  ////////////////////////////////////////////////////////////////////////////
  // Result outputs

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RESULT       <= 32'h0000_0000;
      DEST_INDEX   <= 4'h0;
      RESULT_WRITE <= 1'b0;
      PC_WRITE     <= 1'b0;
      REJECTED     <= 1'b0;
    end else begin
      RESULT_WRITE <= accept && is_data && !is_test;
      PC_WRITE     <= accept && is_data && !is_test && dest_pc;
      REJECTED     <= accept && !is_data;
      if (accept && is_data) begin
        RESULT     <= alu_result;
        DEST_INDEX <= dest_index;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word update and register port

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      current_status_word <= shift_alu_pkg::STATUS_RESET;
    end else if (accept && is_data) begin
      // An executing instruction wins over a software write in the same cycle
      current_status_word <= next_status;
    end else if (REG_WRITE && REG_ADDR == shift_alu_pkg::REG_STATUS) begin
      current_status_word <= REG_WDATA;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      saved_status_word <= shift_alu_pkg::STATUS_RESET;
    end else if (REG_WRITE && REG_ADDR == shift_alu_pkg::REG_SAVED) begin
      saved_status_word <= REG_WDATA;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (REG_READ) begin
      unique case (REG_ADDR)
        shift_alu_pkg::REG_STATUS: REG_RDATA <= current_status_word;
        shift_alu_pkg::REG_SAVED:  REG_RDATA <= saved_status_word;
        shift_alu_pkg::REG_RESULT: REG_RDATA <= RESULT;
        shift_alu_pkg::REG_COST:   REG_RDATA <= {29'h0000_0000, cost_internal, cost_fetches};
        default:                   REG_RDATA <= 32'h0000_0000;
      endcase
    end else begin
      REG_RDATA <= 32'h0000_0000;
    end
  end

endmodule

// ==== logic/shift_alu_pkg.sv ====
package shift_alu_pkg;
  localparam int WORD_W = 32;
  localparam logic [1:0] SHIFT_LSL = 2'h0;
  localparam logic [1:0] SHIFT_LSR = 2'h1;
  localparam logic [1:0] SHIFT_ASR = 2'h2;
  localparam logic [1:0] SHIFT_ROR = 2'h3;
  localparam logic [7:0] COUNT_WORD = 8'h20;
  localparam logic [3:0] OP_AND = 4'h0, OP_EOR = 4'h1, OP_SUB = 4'h2, OP_RSB = 4'h3;
  localparam logic [3:0] OP_ADD = 4'h4, OP_ADC = 4'h5, OP_SBC = 4'h6, OP_RSC = 4'h7;
  localparam logic [3:0] OP_TST = 4'h8, OP_TEQ = 4'h9, OP_CMP = 4'ha, OP_CMN = 4'hb;
  localparam logic [3:0] OP_ORR = 4'hc, OP_MOV = 4'hd, OP_BIC = 4'he, OP_MVN = 4'hf;
  localparam int FLAG_N = 31, FLAG_Z = 30, FLAG_C = 29, FLAG_V = 28;
  localparam int MODE_HI = 4, MODE_LO = 0;
  localparam logic [4:0] USER_MODE = 5'h10;
  localparam logic [31:0] STATUS_RESET = 32'h0000_00d3;
  localparam int CLASS_HI = 27, CLASS_LO = 26, IMM_BIT = 25, OP_HI = 24, OP_LO = 21, S_BIT = 20;
  localparam int RN_HI = 19, RN_LO = 16, RD_HI = 15, RD_LO = 12, RS_HI = 11, RS_LO = 8;
  localparam int SHAMT_HI = 11, SHAMT_LO = 7, STYPE_HI = 6, STYPE_LO = 5, REGSHIFT_BIT = 4;
  localparam int MUL_BIT = 7, RM_HI = 3, RM_LO = 0, ROT_HI = 11, ROT_LO = 8, IMM_HI = 7, IMM_LO = 0;
  localparam logic [1:0] CLASS_DP = 2'h0;
  localparam logic [3:0] PC_INDEX = 4'hf;
  localparam logic [31:0] PC_AHEAD_IMM = 32'h0000_0008;
  localparam logic [31:0] PC_AHEAD_REG = 32'h0000_000c;
  localparam logic [1:0] FETCH_PLAIN = 2'h1;
  localparam logic [1:0] FETCH_PC = 2'h3;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_SAVED = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam logic [7:0] REG_COST = 8'h0c;
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b001,
    ST_INTERNAL = 3'b010,
    ST_FETCH    = 3'b100
  } seq_state_type;
endpackage

// ==== test/shift_alu_data_processing_tb.sv ====
`timescale 1ns/1ns
module shift_alu_data_processing_tb;
  logic        REF_CLK = 1'b0;
  logic        RSTN = 1'b0;
  logic        ISSUE = 1'b0;
  logic [31:0] INSTR = 32'h0;
  logic [31:0] INSTR_ADDR = 32'h0;
  logic [31:0] FIRST_OPERAND = 32'h0;
  logic [31:0] SECOND_OPERAND = 32'h0;
  logic [31:0] SHIFT_COUNT = 32'h0;
  logic [7:0]  REG_ADDR = 8'h0;
  logic [31:0] REG_WDATA = 32'h0;
  logic        REG_WRITE = 1'b0;
  logic        REG_READ = 1'b0;
  logic        READY, RESULT_WRITE, PC_WRITE, REJECTED, FETCH_STROBE, INTERNAL_STROBE, DONE;
  logic [31:0] RESULT, STATUS_WORD, REG_RDATA, rd;
  logic [3:0]  DEST_INDEX;
  logic        rw, pcw, rej;
  int          bad_count = 0;
  int          n_checks = 0;
  int          fetches, internals;

  always #4 REF_CLK = ~REF_CLK;

  shift_alu_data_processing DUT (
    .REF_CLK(REF_CLK), .RSTN(RSTN), .ISSUE(ISSUE), .INSTR(INSTR), .INSTR_ADDR(INSTR_ADDR),
    .FIRST_OPERAND(FIRST_OPERAND), .SECOND_OPERAND(SECOND_OPERAND), .SHIFT_COUNT(SHIFT_COUNT),
    .READY(READY), .RESULT(RESULT), .DEST_INDEX(DEST_INDEX), .RESULT_WRITE(RESULT_WRITE),
    .PC_WRITE(PC_WRITE), .REJECTED(REJECTED), .STATUS_WORD(STATUS_WORD), .FETCH_STROBE(FETCH_STROBE),
    .INTERNAL_STROBE(INTERNAL_STROBE), .DONE(DONE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WRITE(REG_WRITE), .REG_READ(REG_READ), .REG_RDATA(REG_RDATA));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [31:0] dp(input logic [3:0] op, input logic s, input logic [3:0] rn,
                                     input logic [3:0] rd_i, input logic i, input logic [11:0] o2);
    return {4'he, 2'h0, i, op, s, rn, rd_i, o2};
  endfunction

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    REG_WRITE <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge REF_CLK);
    REG_WRITE <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a);
    @(posedge REF_CLK);
    REG_READ <= 1'b1;
    REG_ADDR <= a;
    @(posedge REF_CLK);
    REG_READ <= 1'b0;
    #1;
    rd = REG_RDATA;
  endtask

  // Mode 0x13 keeps the core privileged so saved-status paths stay reachable
  task automatic set_status(input logic c);
    reg_write(shift_alu_pkg::REG_STATUS, {2'h0, c, 29'h13});
  endtask

  // Pulses are caught in the first cycle after acceptance, then strobes counted until idle
  task automatic run_op(input logic [31:0] ins, input logic [31:0] addr, input logic [31:0] op1,
                        input logic [31:0] op2, input logic [31:0] cnt);
    int i;
    @(posedge REF_CLK);
    ISSUE <= 1'b1;
    INSTR <= ins;
    INSTR_ADDR <= addr;
    FIRST_OPERAND <= op1;
    SECOND_OPERAND <= op2;
    SHIFT_COUNT <= cnt;
    @(posedge REF_CLK);
    ISSUE <= 1'b0;
    #1;
    rw = RESULT_WRITE;
    pcw = PC_WRITE;
    rej = REJECTED;
    fetches = 0;
    internals = 0;
    for (i = 0; i < 16 && READY !== 1'b1; i++) begin
      fetches += int'(FETCH_STROBE === 1'b1);
      internals += int'(INTERNAL_STROBE === 1'b1);
      @(posedge REF_CLK);
      #1;
    end
    if (i == 16) begin
      bad_count++;
      give_verdict();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_registers();
    reg_read(shift_alu_pkg::REG_STATUS);
    check(rd, 32'h0000_00d3);
    reg_read(shift_alu_pkg::REG_SAVED);
    check(rd, 32'h0000_00d3);
    reg_read(8'h10);
    check(rd, 32'h0);
  endtask

  task automatic t_reg_shift();
    logic [1:0]  ty [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3};
    logic [31:0] cn [9] = '{32'h100, 32'h4, 32'h20, 32'h21, 32'h20, 32'hff, 32'h40, 32'h20, 32'h24};
    logic [31:0] va [9] = '{32'h8000_0001, 32'hf000_0001, 32'h1, 32'hffff_ffff, 32'h8000_0000,
                            32'hffff_ffff, 32'h8000_0000, 32'h8000_0005, 32'h1b};
    logic        ci [9] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [31:0] ex [9] = '{32'h8000_0001, 32'h10, 32'h0, 32'h0, 32'h0, 32'h0, 32'hffff_ffff,
                            32'h8000_0005, 32'hb000_0001};
    logic        co [9] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    for (int k = 0; k < 9; k++) begin
      set_status(ci[k]);
      run_op(dp(shift_alu_pkg::OP_MOV, 1'b1, 4'h0, 4'h1, 1'b0, {4'h3, 1'b0, ty[k], 1'b1, 4'h2}),
             32'h0, 32'h0, va[k], cn[k]);
      check(RESULT, ex[k]);
      check(32'(STATUS_WORD[29]), 32'(co[k]));
      check(32'(internals), 32'h1);
    end
  endtask

  task automatic t_immediate();
    set_status(1'b1);
    run_op(dp(shift_alu_pkg::OP_MOV, 1'b0, 4'h0, 4'h1, 1'b1, 12'h1ff), 32'h0, 32'h0, 32'h0, 32'h0);
    check(RESULT, 32'hc000_003f);
    check(32'(fetches + internals), 32'h1);
    run_op(dp(shift_alu_pkg::OP_MOV, 1'b0, 4'h0, 4'h1, 1'b1, 12'hf81), 32'h0, 32'h0, 32'h0, 32'h0);
    check(RESULT, 32'h0000_0204);
    run_op(dp(shift_alu_pkg::OP_MOV, 1'b1, 4'h0, 4'h1, 1'b0, 12'h062), 32'h0, 32'h0, 32'h3, 32'h0);
    check(RESULT, 32'h8000_0001);
    check(STATUS_WORD, 32'ha000_0013);
  endtask

  // A junk first operand proves the counter value is substituted, not passed
  task automatic t_pc_operand();
    run_op(dp(shift_alu_pkg::OP_ADD, 1'b0, 4'hf, 4'h3, 1'b1, 12'h0), 32'h100, 32'h55, 32'h0, 32'h0);
    check(RESULT, 32'h0000_0108);
    run_op(dp(shift_alu_pkg::OP_ADD, 1'b0, 4'hf, 4'h3, 1'b0, 12'h412), 32'h100, 32'h55, 32'h5, 32'h0);
    check(RESULT, 32'h0000_0111);
  endtask

  task automatic t_pc_write();
    set_status(1'b1);
    reg_write(shift_alu_pkg::REG_SAVED, 32'h4000_0010);
    run_op(dp(shift_alu_pkg::OP_MOV, 1'b0, 4'h0, 4'hf, 1'b1, 12'h040), 32'h0, 32'h0, 32'h0, 32'h0);
    check({30'h0, pcw, rw}, 32'h3);
    check(STATUS_WORD, 32'h2000_0013);
    check(32'(fetches), 32'h3);
    reg_read(shift_alu_pkg::REG_COST);
    check(rd, 32'h3);
    run_op(dp(shift_alu_pkg::OP_MOV, 1'b1, 4'h0, 4'hf, 1'b0, 12'h412), 32'h0, 32'h0, 32'h20, 32'h1);
    check(RESULT, 32'h0000_0040);
    check(STATUS_WORD, 32'h4000_0010);
    check(32'(fetches * 2 + internals), 32'h7);
    reg_read(shift_alu_pkg::REG_COST);
    check(rd, 32'h7);
    reg_read(shift_alu_pkg::REG_RESULT);
    check(rd, 32'h40);
  endtask

  task automatic t_compare();
    logic [3:0]  op [4] = '{shift_alu_pkg::OP_CMP, shift_alu_pkg::OP_CMN, shift_alu_pkg::OP_TST,
                            shift_alu_pkg::OP_TEQ};
    logic [31:0] a1 [4] = '{32'h5, 32'hffff_ffff, 32'hf0, 32'h1};
    logic [7:0]  im [4] = '{8'h05, 8'h01, 8'h0f, 8'h01};
    set_status(1'b0);
    for (int k = 0; k < 4; k++) begin
      run_op(dp(op[k], 1'b1, 4'h1, 4'h0, 1'b1, {4'h0, im[k]}), 32'h0, a1[k], 32'h0, 32'h0);
      check(32'(rw), 32'h0);
      check(32'(STATUS_WORD[31:28]), 32'h6);
    end
    run_op(dp(shift_alu_pkg::OP_MOV, 1'b1, 4'h0, 4'h1, 1'b0, 12'h392), 32'h0, 32'h0, 32'h0, 32'h0);
    check({31'h0, rej}, 32'h1);
    check(STATUS_WORD, 32'h6000_0013);
  endtask

  task automatic t_legacy();
    set_status(1'b1);
    reg_write(shift_alu_pkg::REG_SAVED, 32'h8000_0011);
    run_op(dp(shift_alu_pkg::OP_TEQ, 1'b1, 4'h1, 4'hf, 1'b1, 12'h001), 32'h0, 32'h7, 32'h0, 32'h0);
    check(STATUS_WORD, 32'h8000_0011);
    check(32'(pcw), 32'h0);
    reg_write(shift_alu_pkg::REG_STATUS, 32'h0000_0010);
    run_op(dp(shift_alu_pkg::OP_TEQ, 1'b1, 4'h1, 4'hf, 1'b1, 12'h001), 32'h0, 32'h7, 32'h0, 32'h0);
    check(STATUS_WORD, 32'h0000_0010);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge REF_CLK);
    RSTN <= 1'b1;
    t_registers();
    t_reg_shift();
    t_immediate();
    t_pc_operand();
    t_pc_write();
    t_compare();
    t_legacy();
    give_verdict();
  end
endmodule

// ==== test/shift_alu_props.sv ====
`timescale 1ns/1ns
module shift_alu_checker (
  input wire logic        REF_CLK,
  input wire logic        RSTN,
  input wire logic        ISSUE,
  input wire logic [31:0] INSTR,
  input wire logic [31:0] SECOND_OPERAND,
  input wire logic [31:0] SHIFT_COUNT,
  input wire logic        READY,
  input wire logic [31:0] RESULT,
  input wire logic [3:0]  DEST_INDEX,
  input wire logic        RESULT_WRITE,
  input wire logic        PC_WRITE,
  input wire logic        REJECTED,
  input wire logic [31:0] STATUS_WORD,
  input wire logic        FETCH_STROBE,
  input wire logic        INTERNAL_STROBE,
  input wire logic        DONE
);
  ////////////////////////////////////////////////////////////////////////////
  // Decode of the word on offer, kept apart from the design's own decoder
  wire logic        go      = ISSUE && READY;
  wire logic        regsh   = !INSTR[25] && INSTR[4];
  wire logic        tst_op  = INSTR[24:23] == 2'h2;
  wire logic        dp_ok   = INSTR[27:26] == 2'h0 && !(regsh && INSTR[7]) && !(tst_op && !INSTR[20]);
  wire logic        pc_dest = INSTR[15:12] == 4'hf && !tst_op;
  wire logic        mov_op  = INSTR[24:21] == 4'hd;
  wire logic [63:0] imm_dbl = {2{24'h0, INSTR[7:0]}};
  wire logic [63:0] imm_shr = imm_dbl >> {INSTR[11:8], 1'b0};
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  bad_encoding_a: assert property (go && INSTR[27:26] == 2'h0 && regsh && INSTR[7] |=> REJECTED && !RESULT_WRITE)
    else $error("register shift with bit 7 set was executed");
  imm_rotate_a: assert property (go && dp_ok && INSTR[25] && mov_op |=> RESULT == $past(imm_shr[31:0]))
    else $error("immediate operand rotated wrongly");
  count_zero_a: assert property (go && dp_ok && regsh && mov_op && SHIFT_COUNT[7:0] == 8'h00 && INSTR[3:0] != 4'hf
    |=> RESULT == $past(SECOND_OPERAND))
    else $error("zero low byte count changed the operand");
  test_no_write_a: assert property (go && dp_ok && tst_op |=> !RESULT_WRITE && !PC_WRITE)
    else $error("test or compare opcode wrote a register");
  pc_keep_status_a: assert property (go && dp_ok && pc_dest && !INSTR[20] |=> PC_WRITE && $stable(STATUS_WORD))
    else $error("counter write without flag bit touched status");
  pc_write_pair_a: assert property (PC_WRITE |-> RESULT_WRITE && DEST_INDEX == 4'hf)
    else $error("counter write not paired with destination 15");
  plain_cost_a: assert property (go && dp_ok && !regsh && !pc_dest
    |=> FETCH_STROBE && DONE && !INTERNAL_STROBE ##1 READY)
    else $error("plain operation cost is not one fetch");
  pc_cost_a: assert property (go && dp_ok && pc_dest && !regsh
    |=> (FETCH_STROBE && !DONE)[*2] ##1 (FETCH_STROBE && DONE) ##1 READY)
    else $error("counter write cost is not three fetches");
  regshift_cost_a: assert property (go && dp_ok && regsh && !pc_dest
    |=> INTERNAL_STROBE && !FETCH_STROBE ##1 FETCH_STROBE && DONE ##1 READY)
    else $error("register shift cost is not fetch plus internal cycle");
  flag_update_a: assert property (go && dp_ok && mov_op && INSTR[20] && INSTR[15:12] != 4'hf
    |=> STATUS_WORD[31] == RESULT[31] && STATUS_WORD[30] == (RESULT == 32'h0))
    else $error("negative or zero flag disagrees with result");
endmodule

bind shift_alu_data_processing shift_alu_checker u_chk (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .ISSUE(ISSUE), .INSTR(INSTR), .SECOND_OPERAND(SECOND_OPERAND),
  .SHIFT_COUNT(SHIFT_COUNT), .READY(READY), .RESULT(RESULT), .DEST_INDEX(DEST_INDEX),
  .RESULT_WRITE(RESULT_WRITE), .PC_WRITE(PC_WRITE), .REJECTED(REJECTED), .STATUS_WORD(STATUS_WORD),
  .FETCH_STROBE(FETCH_STROBE), .INTERNAL_STROBE(INTERNAL_STROBE), .DONE(DONE));
